// ---- core/fec_hdr_map.svh ----
// Constants for the repair header codec
//
// Behaviour
// - Header opens with retransmit flag then fixed-block flag, selecting the variant.
// - Both flags set is never sent; such received packets are dropped.
// - Both flags clear selects the flexible bitmask layout.
// - 16-bit length field holds octets after the 12-byte fixed header.
// - 32-bit timestamp field restores the timestamp of recovered packets.
// - One block per protected stream, in CSRC list order, when count exceeds one; the builder sends at most 4 blocks.
// - Base sequence holds lowest protected number; comparisons wrap around.
// - Mask bit j protects base plus j; bit 0 is most significant.
// - Masks are 15, 46 or 110 bits; continuation flag 1 means more.
// - Repair payload covers everything after each packet's fixed header; the code keeps at most 16 payload words.
// - Fixed-block variant holds base, column count and row count per stream.
// - Column and row counts are 8 bits, at most 255.
// - Columns above one, zero rows: row protection only, no column repair.
// - Rows equal one: all row repairs are sent before column repairs.
// - Rows above one: column repair over every L-th packet, D packets.
// - One column, zero rows: packet is a plain retransmission.
// - Retransmission puts base sequence in the length field's place; no masks.
// - Retransmission carries the source stream identifier in the header.
// - Retransmission prepends a header to the unchanged source content.
// - One repair stream may retransmit and protect several source streams.
// - Timestamp rate must exceed 1000 Hz, ideally matching the source.
// - Protection span is configured in microseconds.
`ifndef FEC_HDR_MAP_SVH
`define FEC_HDR_MAP_SVH
`define FH_R_BIT        31
`define FH_F_BIT        30
`define FH_K1_BIT       15
`define FH_K2_BIT       31
`define FH_SEG1_BITS    15
`define FH_SEG2_BITS    46
`define FH_SEG3_BITS    110
`define FH_FIXED_BYTES  12
`define FH_MIN_RATE_HZ  32'h0000_03E8
`define FH_CLK_HZ       32'h0131_2D00
`define FH_CYC_PER_US   (`FH_CLK_HZ / 32'h000F_4240)
`define FH_FIFO_DEPTH   16
`define FH_FIFO_WIDTH   33
`define FH_PAY_WORDS    16
`define FH_MAX_STREAMS  4
`endif

// ---- core/fec_hdr_pkg.sv ----
// Types for the repair header codec
package fec_hdr_pkg;
	typedef enum logic [1:0] {
		VAR_MASK  = 2'h0,
		VAR_FIXED = 2'h1,
		VAR_RETX  = 2'h2,
		VAR_BAD   = 2'h3
	} variant_t;
	typedef enum logic [6:0] {
		B_IDLE = 7'h01, B_W0 = 7'h02, B_W1 = 7'h04, B_BLK = 7'h08,
		B_M2 = 7'h10, B_M3A = 7'h20, B_PAY = 7'h40
	} bstate_t;
	typedef enum logic [6:0] {
		P_W0 = 7'h01, P_W1 = 7'h02, P_BLK = 7'h04, P_M2 = 7'h08,
		P_M3A = 7'h10, P_M3B = 7'h20, P_SKIP = 7'h40
	} pstate_t;
	typedef enum logic [2:0] {
		KIND_MASK = 3'h0, KIND_ROW = 3'h1, KIND_ROWCOL = 3'h2,
		KIND_COL = 3'h3, KIND_RETX = 3'h4, KIND_BAD = 3'h5
	} kind_t;
endpackage

// ---- core/fec_hdr_codec.sv ----
// Repair header builder, parser and output FIFO
`include "fec_hdr_map.svh"

module fec_word_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 16
) (
	input  wire logic             core_clk_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0]  mem_r [DEPTH];
	logic [AW-1:0]     wp_r;
	logic [AW-1:0]     rp_r;
	logic [AW:0]       cnt_r;
	logic              push;
	logic              pop;

	assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
	assign push = in_valid_i && in_ready_o;
	assign pop = (cnt_r != '0) && (!out_valid_o || out_ready_i);

	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_r[wp_r] <= in_data_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Registered output stage
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end else if (pop) begin
			out_valid_o <= 1'b1;
			out_data_o <= mem_r[rp_r];
		end else if (out_ready_i) begin
			out_valid_o <= 1'b0;
		end
	end
endmodule // fec_word_fifo

module rtp_fec_header_codec (
	// Clock and reset
	input  wire logic          core_clk_i,
	input  wire logic          reset_i,
	// Source packet accumulation
	input  wire logic          src_start_i,
	input  wire logic          src_valid_i,
	input  wire logic [13:0]   src_hdr_bits_i,
	input  wire logic [15:0]   src_len_i,
	input  wire logic [31:0]   src_ts_i,
	input  wire logic          src_word_valid_i,
	input  wire logic [3:0]    src_word_idx_i,
	input  wire logic [31:0]   src_word_i,
	// Stream descriptors
	input  wire logic          desc_we_i,
	input  wire logic [1:0]    desc_idx_i,
	input  wire logic [15:0]   first_protected_seq_i,
	input  wire logic [109:0]  desc_mask_i,
	input  wire logic [7:0]    desc_cols_i,
	input  wire logic [7:0]    desc_rows_i,
	input  wire logic [31:0]   desc_ssrc_i,
	// Build control
	input  wire logic          bld_start_i,
	input  wire logic [1:0]    bld_variant_i,
	input  wire logic [2:0]    bld_streams_i,
	input  wire logic          bld_col_i,
	input  wire logic [7:0]    bld_rows_i,
	input  wire logic          bld_block_clr_i,
	output logic               bld_busy_o,
	output logic               bld_err_o,
	// Outgoing header words
	output logic [31:0]        tx_data_o,
	output logic               tx_last_o,
	output logic               tx_valid_o,
	input  wire logic          tx_ready_i,
	// Incoming header words
	input  wire logic          rx_valid_i,
	input  wire logic [31:0]   rx_word_i,
	input  wire logic          rx_last_i,
	input  wire logic [3:0]    rx_cc_i,
	input  wire logic [7:0]    cfg_cols_i,
	input  wire logic [7:0]    cfg_rows_i,
	input  wire logic          cfg_ld_ok_i,
	// Parsed fields
	output logic [1:0]         rx_variant_o,
	output logic [13:0]        rx_hdr_bits_o,
	output logic [15:0]        rx_len_o,
	output logic [31:0]        timestamp_restore_field_o,
	output logic [31:0]        rx_ssrc_o,
	output logic               rx_blk_valid_o,
	output logic [15:0]        rx_blk_base_o,
	output logic [109:0]       rx_blk_mask_o,
	output logic [7:0]         rx_blk_cols_o,
	output logic [7:0]         rx_blk_rows_o,
	output logic [2:0]         rx_blk_kind_o,
	output logic               rx_drop_o,
	// Session settings and protection query
	input  wire logic [31:0]   rate_hz_i,
	input  wire logic [15:0]   win_us_i,
	output logic               rate_bad_o,
	output logic [31:0]        win_cyc_o,
	input  wire logic [15:0]   q_seq_i,
	output logic               q_hit_o
);
	// Offset from base with 16-bit wrap, then mask bit test
	function automatic logic prot_hit(input logic [15:0] base,
		input logic [109:0] mask, input logic [15:0] seq);
		logic [15:0] off;
		off = seq - base;
		prot_hit = (off < 16'h006E) && mask[7'(16'h006D - off)];
	endfunction

	function automatic logic [1:0] mask_segs(input logic [109:0] mask);
		mask_segs = (|mask[63:0]) ? 2'h3 : ((|mask[94:64]) ? 2'h2 : 2'h1);
	endfunction

	function automatic fec_hdr_pkg::kind_t ld_kind(input logic [7:0] l,
		input logic [7:0] d);
		if (l == 8'h00) begin
			ld_kind = fec_hdr_pkg::KIND_BAD;
		end else if (l == 8'h01 && d == 8'h00) begin
			ld_kind = fec_hdr_pkg::KIND_RETX;
		end else if (d == 8'h00) begin
			ld_kind = fec_hdr_pkg::KIND_ROW;
		end else if (d == 8'h01) begin
			ld_kind = fec_hdr_pkg::KIND_ROWCOL;
		end else begin
			ld_kind = fec_hdr_pkg::KIND_COL;
		end
	endfunction

	// Accumulators and descriptors
	logic [13:0]           hdr_acc_r;
	logic [15:0]           len_acc_r;
	logic [31:0]           ts_acc_r;
	logic [31:0]           pay_acc_r [`FH_PAY_WORDS];
	logic [4:0]            pay_cnt_r;
	logic [15:0]           base_r  [`FH_MAX_STREAMS];
	logic [109:0]          mask_r  [`FH_MAX_STREAMS];
	logic [7:0]            cols_r  [`FH_MAX_STREAMS];
	logic [7:0]            rows_r  [`FH_MAX_STREAMS];
	logic [31:0]           ssrc_r  [`FH_MAX_STREAMS];
	// Builder
	fec_hdr_pkg::bstate_t  b_st_r;
	fec_hdr_pkg::variant_t bld_var_r;
	logic [1:0]            s_r;
	logic [1:0]            s_last_r;
	logic [3:0]            w_r;
	logic [7:0]            row_cnt_r;
	logic [1:0]            segs;
	logic [4:0]            pay_n;
	logic [31:0]           fin_data;
	logic                  fin_last;
	logic                  fin_valid;
	logic                  fin_rdy;
	logic                  stream_end;
	logic                  start_ok;
	// Parser
	fec_hdr_pkg::pstate_t  p_st_r;
	logic [3:0]            blk_cnt_r;
	logic [3:0]            n_blk;
	fec_hdr_pkg::pstate_t  p_after_blk;
	fec_hdr_pkg::variant_t rx_var;

	// XOR over every protected source packet; short ones leave zeros
	always_ff @(posedge core_clk_i) begin
		if (reset_i || src_start_i) begin
			hdr_acc_r <= '0;
			len_acc_r <= '0;
			ts_acc_r <= '0;
			pay_cnt_r <= '0;
			for (int i = 0; i < `FH_PAY_WORDS; i++) begin
				pay_acc_r[i] <= '0;
			end
		end else begin
			if (src_valid_i) begin
				hdr_acc_r <= hdr_acc_r ^ src_hdr_bits_i;
				len_acc_r <= len_acc_r ^ src_len_i;
				ts_acc_r <= ts_acc_r ^ src_ts_i;
			end
			if (src_word_valid_i) begin
				pay_acc_r[src_word_idx_i] <=
					pay_acc_r[src_word_idx_i] ^ src_word_i;
				if ({1'b0, src_word_idx_i} >= pay_cnt_r) begin
					pay_cnt_r <= {1'b0, src_word_idx_i} + 5'h01;
				end
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (desc_we_i) begin
			base_r[desc_idx_i] <= first_protected_seq_i;
			mask_r[desc_idx_i] <= desc_mask_i;
			cols_r[desc_idx_i] <= desc_cols_i;
			rows_r[desc_idx_i] <= desc_rows_i;
			ssrc_r[desc_idx_i] <= desc_ssrc_i;
		end
	end

	// Word builder
	assign segs = mask_segs(mask_r[s_r]);
	assign pay_n = (pay_cnt_r == 5'h00) ? 5'h01 : pay_cnt_r;
	assign fin_valid = (b_st_r != fec_hdr_pkg::B_IDLE);
	assign fin_last = (b_st_r == fec_hdr_pkg::B_PAY) &&
		({1'b0, w_r} == pay_n - 5'h01);
	assign start_ok = (bld_variant_i != fec_hdr_pkg::VAR_BAD) &&
		!(bld_variant_i == fec_hdr_pkg::VAR_FIXED && bld_col_i &&
		row_cnt_r < bld_rows_i);
	assign stream_end = (s_r == s_last_r);

	always_comb begin
		fin_data = '0;
		case (b_st_r)
			fec_hdr_pkg::B_W0: begin
				fin_data = {bld_var_r, hdr_acc_r, len_acc_r};
				if (bld_var_r == fec_hdr_pkg::VAR_RETX) begin
					fin_data[15:0] = base_r[0];
				end
			end
			fec_hdr_pkg::B_W1: fin_data = ts_acc_r;
			fec_hdr_pkg::B_BLK: begin
				case (bld_var_r)
					fec_hdr_pkg::VAR_RETX: fin_data = ssrc_r[0];
					fec_hdr_pkg::VAR_FIXED:
						fin_data = {base_r[s_r], cols_r[s_r], rows_r[s_r]};
					default: fin_data = {base_r[s_r], segs != 2'h1,
						mask_r[s_r][109:95]};
				endcase
			end
			fec_hdr_pkg::B_M2: fin_data = {segs == 2'h3, mask_r[s_r][94:64]};
			fec_hdr_pkg::B_M3A: fin_data = w_r[0] ? mask_r[s_r][31:0] :
				mask_r[s_r][63:32];
			fec_hdr_pkg::B_PAY: fin_data = pay_acc_r[w_r];
			default: fin_data = '0;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			b_st_r <= fec_hdr_pkg::B_IDLE;
			bld_var_r <= fec_hdr_pkg::VAR_MASK;
			s_r <= '0;
			s_last_r <= '0;
			w_r <= '0;
			bld_busy_o <= 1'b0;
			bld_err_o <= 1'b0;
		end else begin
			bld_err_o <= 1'b0;
			case (b_st_r)
				fec_hdr_pkg::B_IDLE: begin
					if (bld_start_i && start_ok) begin
						bld_var_r <= fec_hdr_pkg::variant_t'(bld_variant_i);
						s_r <= '0;
						w_r <= '0;
						s_last_r <= (bld_streams_i > 3'h4) ? 2'h3 :
							((bld_streams_i == 3'h0) ? 2'h0 :
							2'(bld_streams_i - 3'h1));
						b_st_r <= fec_hdr_pkg::B_W0;
						bld_busy_o <= 1'b1;
					end else if (bld_start_i) begin
						bld_err_o <= 1'b1;
					end
				end
				fec_hdr_pkg::B_W0: if (fin_rdy) begin
					b_st_r <= fec_hdr_pkg::B_W1;
				end
				fec_hdr_pkg::B_W1: if (fin_rdy) begin
					b_st_r <= fec_hdr_pkg::B_BLK;
				end
				fec_hdr_pkg::B_BLK: if (fin_rdy) begin
					if (bld_var_r == fec_hdr_pkg::VAR_RETX) begin
						b_st_r <= fec_hdr_pkg::B_PAY;
					end else if (bld_var_r == fec_hdr_pkg::VAR_MASK &&
						segs != 2'h1) begin
						b_st_r <= fec_hdr_pkg::B_M2;
					end else if (!stream_end) begin
						s_r <= s_r + 2'h1;
					end else begin
						b_st_r <= fec_hdr_pkg::B_PAY;
					end
				end
				fec_hdr_pkg::B_M2: if (fin_rdy) begin
					if (segs == 2'h3) begin
						b_st_r <= fec_hdr_pkg::B_M3A;
					end else if (!stream_end) begin
						s_r <= s_r + 2'h1;
						b_st_r <= fec_hdr_pkg::B_BLK;
					end else begin
						b_st_r <= fec_hdr_pkg::B_PAY;
					end
				end
				fec_hdr_pkg::B_M3A: if (fin_rdy) begin
					w_r <= w_r + 4'h1;
					if (w_r[0]) begin
						w_r <= '0;
						s_r <= stream_end ? s_r : s_r + 2'h1;
						b_st_r <= stream_end ? fec_hdr_pkg::B_PAY :
							fec_hdr_pkg::B_BLK;
					end
				end
				fec_hdr_pkg::B_PAY: if (fin_rdy) begin
					w_r <= w_r + 4'h1;
					if (fin_last) begin
						b_st_r <= fec_hdr_pkg::B_IDLE;
						bld_busy_o <= 1'b0;
					end
				end
				default: b_st_r <= fec_hdr_pkg::B_IDLE;
			endcase
		end
	end

	// Row repairs counted so column repairs can wait for them
	always_ff @(posedge core_clk_i) begin
		if (reset_i || bld_block_clr_i) begin
			row_cnt_r <= '0;
		end else if (b_st_r == fec_hdr_pkg::B_IDLE && bld_start_i &&
			start_ok && bld_variant_i == fec_hdr_pkg::VAR_FIXED &&
			!bld_col_i && row_cnt_r != 8'hFF) begin
			row_cnt_r <= row_cnt_r + 8'h01;
		end
	end

	fec_word_fifo #(
		.WIDTH (`FH_FIFO_WIDTH),
		.DEPTH (`FH_FIFO_DEPTH)
	) u_fifo (
		.core_clk_i  (core_clk_i),
		.reset_i     (reset_i),
		.in_data_i   ({fin_last, fin_data}),
		.in_valid_i  (fin_valid),
		.in_ready_o  (fin_rdy),
		.out_data_o  ({tx_last_o, tx_data_o}),
		.out_valid_o (tx_valid_o),
		.out_ready_i (tx_ready_i)
	);

	// Header parser
	assign rx_var = fec_hdr_pkg::variant_t'(rx_word_i[`FH_R_BIT:`FH_F_BIT]);
	assign n_blk = (rx_cc_i == 4'h0) ? 4'h1 : rx_cc_i;
	assign p_after_blk = (blk_cnt_r + 4'h1 >= n_blk) ?
		fec_hdr_pkg::P_SKIP : fec_hdr_pkg::P_BLK;

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			p_st_r <= fec_hdr_pkg::P_W0;
			blk_cnt_r <= '0;
			rx_variant_o <= '0;
			rx_hdr_bits_o <= '0;
			rx_len_o <= '0;
			timestamp_restore_field_o <= '0;
			rx_ssrc_o <= '0;
			rx_blk_valid_o <= 1'b0;
			rx_blk_base_o <= '0;
			rx_blk_mask_o <= '0;
			rx_blk_cols_o <= '0;
			rx_blk_rows_o <= '0;
			rx_blk_kind_o <= '0;
			rx_drop_o <= 1'b0;
		end else begin
			rx_blk_valid_o <= 1'b0;
			rx_drop_o <= 1'b0;
			if (rx_valid_i) begin
				case (p_st_r)
					fec_hdr_pkg::P_W0: begin
						rx_variant_o <= rx_word_i[`FH_R_BIT:`FH_F_BIT];
						rx_hdr_bits_o <= rx_word_i[29:16];
						blk_cnt_r <= '0;
						if (rx_var == fec_hdr_pkg::VAR_BAD) begin
							rx_drop_o <= 1'b1;
							p_st_r <= fec_hdr_pkg::P_SKIP;
						end else begin
							if (rx_var == fec_hdr_pkg::VAR_RETX) begin
								rx_blk_base_o <= rx_word_i[15:0];
							end else begin
								rx_len_o <= rx_word_i[15:0];
							end
							p_st_r <= fec_hdr_pkg::P_W1;
						end
					end
					fec_hdr_pkg::P_W1: begin
						timestamp_restore_field_o <= rx_word_i;
						p_st_r <= fec_hdr_pkg::P_BLK;
					end
					fec_hdr_pkg::P_BLK: begin
						blk_cnt_r <= blk_cnt_r + 4'h1;
						if (rx_variant_o == fec_hdr_pkg::VAR_RETX) begin
							rx_ssrc_o <= rx_word_i;
							rx_blk_kind_o <= fec_hdr_pkg::KIND_RETX;
							rx_blk_valid_o <= 1'b1;
							p_st_r <= fec_hdr_pkg::P_SKIP;
						end else if (rx_variant_o == fec_hdr_pkg::VAR_FIXED) begin
							rx_blk_base_o <= rx_word_i[31:16];
							p_st_r <= p_after_blk;
							if (rx_word_i[15:0] == 16'h0000) begin
								rx_blk_cols_o <= cfg_cols_i;
								rx_blk_rows_o <= cfg_rows_i;
								rx_blk_kind_o <= ld_kind(cfg_cols_i, cfg_rows_i);
								rx_blk_valid_o <= cfg_ld_ok_i;
								rx_drop_o <= !cfg_ld_ok_i;
							end else begin
								rx_blk_cols_o <= rx_word_i[15:8];
								rx_blk_rows_o <= rx_word_i[7:0];
								rx_blk_kind_o <= ld_kind(rx_word_i[15:8],
									rx_word_i[7:0]);
								rx_blk_valid_o <= 1'b1;
							end
						end else begin
							rx_blk_base_o <= rx_word_i[31:16];
							rx_blk_mask_o <= {rx_word_i[14:0], 95'h0};
							rx_blk_kind_o <= fec_hdr_pkg::KIND_MASK;
							rx_blk_valid_o <= !rx_word_i[`FH_K1_BIT];
							p_st_r <= rx_word_i[`FH_K1_BIT] ?
								fec_hdr_pkg::P_M2 : p_after_blk;
						end
					end
					fec_hdr_pkg::P_M2: begin
						rx_blk_mask_o[94:64] <= rx_word_i[30:0];
						rx_blk_valid_o <= !rx_word_i[`FH_K2_BIT];
						p_st_r <= rx_word_i[`FH_K2_BIT] ?
							fec_hdr_pkg::P_M3A : fec_hdr_pkg::pstate_t'(
							(blk_cnt_r >= n_blk) ? fec_hdr_pkg::P_SKIP :
							fec_hdr_pkg::P_BLK);
					end
					fec_hdr_pkg::P_M3A: begin
						rx_blk_mask_o[63:32] <= rx_word_i;
						p_st_r <= fec_hdr_pkg::P_M3B;
					end
					fec_hdr_pkg::P_M3B: begin
						rx_blk_mask_o[31:0] <= rx_word_i;
						rx_blk_valid_o <= 1'b1;
						p_st_r <= (blk_cnt_r >= n_blk) ? fec_hdr_pkg::P_SKIP :
							fec_hdr_pkg::P_BLK;
					end
					fec_hdr_pkg::P_SKIP: p_st_r <= fec_hdr_pkg::P_SKIP;
					default: p_st_r <= fec_hdr_pkg::P_W0;
				endcase
				if (rx_last_i) begin
					p_st_r <= fec_hdr_pkg::P_W0;
				end
			end
		end
	end

	// Session settings and query
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			rate_bad_o <= 1'b0;
			win_cyc_o <= '0;
			q_hit_o <= 1'b0;
		end else begin
			rate_bad_o <= (rate_hz_i <= `FH_MIN_RATE_HZ);
			win_cyc_o <= 32'(win_us_i * `FH_CYC_PER_US);
			q_hit_o <= prot_hit(base_r[0], mask_r[0], q_seq_i);
		end
	end

	// Checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	a_err_bad_variant: assert property (
		b_st_r == fec_hdr_pkg::B_IDLE && bld_start_i &&
		bld_variant_i == 2'h3 |=> bld_err_o &&
		b_st_r == fec_hdr_pkg::B_IDLE) else $error("bad variant built");
	a_drop_bad_rx: assert property (rx_valid_i &&
		p_st_r == fec_hdr_pkg::P_W0 && rx_word_i[31:30] == 2'h3 |=>
		rx_drop_o && !rx_blk_valid_o)
		else $error("bad variant not dropped");
	a_flag_bits: assert property (b_st_r == fec_hdr_pkg::B_W0 |->
		fin_data[31:30] == bld_var_r && bld_var_r != 2'h3)
		else $error("flag bits wrong");
	a_retx_base: assert property (b_st_r == fec_hdr_pkg::B_W0 &&
		bld_var_r == fec_hdr_pkg::VAR_RETX |-> fin_data[15:0] == base_r[0])
		else $error("retransmit base missing");
	a_len_field: assert property (b_st_r == fec_hdr_pkg::B_W0 &&
		bld_var_r != fec_hdr_pkg::VAR_RETX |-> fin_data[15:0] == len_acc_r)
		else $error("length field wrong");
	a_ts_field: assert property (b_st_r == fec_hdr_pkg::B_W0 &&
		fin_rdy |=> fin_data == ts_acc_r)
		else $error("timestamp field wrong");
	a_mask_kbit: assert property (b_st_r == fec_hdr_pkg::B_BLK &&
		bld_var_r == fec_hdr_pkg::VAR_MASK && fin_rdy |->
		fin_data[15] == (segs != 2'h1) ##1
		(b_st_r == fec_hdr_pkg::B_M2) == $past(fin_data[15]))
		else $error("continuation flag wrong");
	a_col_order: assert property (b_st_r == fec_hdr_pkg::B_IDLE &&
		bld_start_i && bld_variant_i == 2'h1 && bld_col_i &&
		row_cnt_r < bld_rows_i |=> bld_err_o ##1 !bld_err_o)
		else $error("column before rows");
	a_ld_zero: assert property (rx_valid_i &&
		p_st_r == fec_hdr_pkg::P_BLK && rx_variant_o == 2'h1 &&
		rx_word_i[15:0] == 16'h0000 && !cfg_ld_ok_i |=> rx_drop_o)
		else $error("zero counts accepted");
	a_rate_low: assert property (
		rate_hz_i <= 32'h0000_03E8 |=> rate_bad_o)
		else $error("low rate not flagged");

	c_mask_build: cover property (b_st_r == fec_hdr_pkg::B_M3A ##[1:40]
		tx_last_o && tx_valid_o);
	c_retx_build: cover property (bld_var_r == fec_hdr_pkg::VAR_RETX &&
		b_st_r == fec_hdr_pkg::B_PAY);
	c_rx_fixed: cover property (rx_blk_valid_o &&
		rx_blk_kind_o == fec_hdr_pkg::KIND_ROWCOL);
	c_fifo_full: cover property (fin_valid && !fin_rdy);
endmodule // rtp_fec_header_codec

// ---- tb/fec_sink.sv ----
// Remote endpoint model that takes repair header words
module fec_sink (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic [31:0] data_i,
	input  wire logic        last_i,
	input  wire logic        valid_i,
	output logic             ready_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] words [0:31];
	int          n = 0;
	int          cyc = 0;
	int          seed = 67;
	logic        done = 0;
	initial ready_o = 0;
	// Long stall first so the buffer fills, then random stalls
	always @(negedge clk_i) begin
		cyc <= cyc + 1;
		ready_o <= (cyc > 80) && ($random(seed) % 2 != 0);
	end
	always @(posedge clk_i) begin
		if (!reset_i && valid_i && ready_o) begin
			words[n] <= data_i;
			n <= n + 1;
			if (last_i) done <= 1;
		end
	end
endmodule // fec_sink

// ---- tb/rtp_fec_header_codec_test.sv ----
// Self-checking bench of the repair header codec
module rtp_fec_header_codec_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_i = 0, reset_i = 1, src_start_i = 0, src_valid_i = 0;
	logic src_word_valid_i = 0, desc_we_i = 0, bld_start_i = 0, bld_col_i = 0;
	logic bld_block_clr_i = 0, rx_valid_i = 0, rx_last_i = 0, cfg_ld_ok_i = 0;
	logic [13:0] src_hdr_bits_i = 0;
	logic [15:0] src_len_i = 0, first_protected_seq_i = 0, win_us_i = 0;
	logic [15:0] q_seq_i = 0;
	logic [31:0] src_ts_i = 0, src_word_i = 0, desc_ssrc_i = 0, rx_word_i = 0;
	logic [31:0] rate_hz_i = 0;
	logic [3:0] src_word_idx_i = 0, rx_cc_i = 1;
	logic [1:0] desc_idx_i = 0, bld_variant_i = 0;
	logic [109:0] desc_mask_i = 0;
	logic [7:0] desc_cols_i = 0, desc_rows_i = 0, bld_rows_i = 0;
	logic [7:0] cfg_cols_i = 0, cfg_rows_i = 0;
	logic [2:0] bld_streams_i = 1;
	logic bld_busy_o, bld_err_o, tx_last_o, tx_valid_o, tx_ready_i, q_hit_o;
	logic rx_blk_valid_o, rx_drop_o, rate_bad_o;
	logic [31:0] tx_data_o, timestamp_restore_field_o, rx_ssrc_o, win_cyc_o;
	logic [1:0] rx_variant_o;
	logic [13:0] rx_hdr_bits_o;
	logic [15:0] rx_len_o, rx_blk_base_o;
	logic [109:0] rx_blk_mask_o;
	logic [7:0] rx_blk_cols_o, rx_blk_rows_o;
	logic [2:0] rx_blk_kind_o, kind_cap;
	logic [31:0] pay [0:15];
	logic [31:0] expw;
	logic [15:0] off;
	int err_count = 0, n_tests = 0, seed = 67, nblk = 0, ndrop = 0, nerr = 0;
	int nb, nd, k;
	rtp_fec_header_codec u_dut (.*);
	fec_sink u_sink (.clk_i(core_clk_i), .reset_i(reset_i), .data_i(tx_data_o),
		.last_i(tx_last_o), .valid_i(tx_valid_o), .ready_o(tx_ready_i));
	initial forever #25 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		if (rx_blk_valid_o === 1'b1) nblk <= nblk + 1;
		if (rx_blk_valid_o === 1'b1) kind_cap <= rx_blk_kind_o;
		if (rx_drop_o === 1'b1) ndrop <= ndrop + 1;
		if (bld_err_o === 1'b1) nerr <= nerr + 1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic rx_pkt(input logic [31:0] w0, w2);
		rx_valid_i = 1;
		rx_word_i = w0;
		tick(1);
		rx_word_i = 32'h1357_9BDF;
		tick(1);
		rx_word_i = w2;
		rx_last_i = 1;
		tick(1);
		rx_valid_i = 0;
		rx_last_i = 0;
		tick(3);
	endtask
	initial begin
		tick(4);
		reset_i = 0;
		src_start_i = 1;
		tick(1);
		src_start_i = 0;
		src_valid_i = 1;
		{src_hdr_bits_i, src_len_i, src_ts_i} = {14'h01A5, 16'h0123, 32'h1111_0000};
		tick(1);
		{src_hdr_bits_i, src_len_i, src_ts_i} = {14'h00F0, 16'h0040, 32'h0000_2222};
		tick(1);
		src_valid_i = 0;
		src_word_valid_i = 1;
		for (int i = 0; i < 16; i++) begin
			src_word_idx_i = i;
			src_word_i = $random(seed);
			pay[i] = src_word_i;
			tick(1);
		end
		src_word_valid_i = 0;
		desc_we_i = 1;
		first_protected_seq_i = 16'hFFFC;
		desc_mask_i = {1'b1, 8'h00, 1'b1, 100'h0};
		tick(1);
		desc_we_i = 0;
		bld_start_i = 1;
		bld_variant_i = 2'h3;
		tick(1);
		bld_start_i = 0;
		tick(3);
		chk("refused start", nerr, 1);
		bld_variant_i = 2'h1;
		bld_col_i = 1;
		bld_rows_i = 8'h01;
		bld_block_clr_i = 1;
		bld_start_i = 1;
		tick(1);
		bld_start_i = 0;
		bld_block_clr_i = 0;
		bld_col_i = 0;
		tick(3);
		chk("column too early", nerr, 2);
		bld_variant_i = 2'h0;
		bld_start_i = 1;
		tick(1);
		bld_start_i = 0;
		chk("busy", bld_busy_o, 1);
		tick(30);
		chk("busy while full", bld_busy_o, 1);
		k = 0;
		while (u_sink.done !== 1'b1) begin
			tick(1);
			if (++k > 400) begin
				err_count++;
				tally_and_finish();
			end
		end
		chk("word count", u_sink.n, 19);
		chk("w0", u_sink.words[0], {2'b00, 14'h0155, 16'h0163});
		chk("w1", u_sink.words[1], 32'h1111_2222);
		chk("block", u_sink.words[2], {16'hFFFC, 1'b0, desc_mask_i[109:95]});
		chk("rebuilt len", u_sink.words[0][15:0] ^ 16'h0040, 16'h0123);
		chk("rebuilt ts", u_sink.words[1] ^ 32'h0000_2222, 32'h1111_0000);
		for (int i = 0; i < 16; i++) chk("payload", u_sink.words[3+i], pay[i]);
		$display("test build done");
		for (int i = 0; i < 8; i++) begin
			off = (i < 2) ? 16'(i * 9) : 16'($random(seed) & 32'h0000_00FF);
			q_seq_i = first_protected_seq_i + off;
			tick(2);
			chk("hit", q_hit_o, (off < 110) && desc_mask_i[109 - (off % 110)]);
			rate_hz_i = (i == 0) ? 32'h0000_03E8 : (i == 1) ? 32'h0000_03E9 : $random(seed);
			win_us_i = $random(seed);
			tick(2);
			chk("rate", rate_bad_o, rate_hz_i <= 32'h0000_03E8);
			chk("window", win_cyc_o, win_us_i * 32'h0000_0014);
		end
		$display("test query done");
		for (int i = 0; i < 5; i++) begin
			expw = {16'h0005, 8'h05, 8'h00};
			case (i)
				1: expw[7:0] = 8'h01;
				2: expw[7:0] = 8'h03;
				3: expw[15:8] = 8'h01;
				4: expw[15:0] = 16'h0004;
				default: ;
			endcase
			nb = nblk;
			rx_pkt({2'b01, 14'h0ABC, 16'h0077}, expw);
			chk("blocks", nblk - nb, 1);
			chk("variant", rx_variant_o, 1);
			chk("hdr", rx_hdr_bits_o, 14'h0ABC);
			chk("base", rx_blk_base_o, 16'h0005);
			chk("counts", {rx_blk_cols_o, rx_blk_rows_o}, expw[15:0]);
			chk("kind", kind_cap, (i == 0) ? 1 : (i == 3) ? 4 : i + 1);
			chk("len", rx_len_o, 16'h0077);
			chk("ts", timestamp_restore_field_o, 32'h1357_9BDF);
		end
		nd = ndrop;
		rx_pkt({2'b01, 30'h0}, 32'h0009_0000);
		rx_pkt({2'b11, 30'h0}, 32'h0009_0501);
		chk("drops", ndrop - nd, 2);
		rx_pkt({2'b00, 14'h0000, 16'h0021}, {16'h1234, 1'b0, 15'h4001});
		chk("mask", rx_blk_mask_o[109:95], 15'h4001);
		chk("mask base", rx_blk_base_o, 16'h1234);
		chk("mask kind", kind_cap, 0);
		rx_pkt({2'b10, 14'h0000, 16'h0BEE}, 32'hC0DE_F00D);
		chk("retx base", rx_blk_base_o, 16'h0BEE);
		chk("retx ssrc", rx_ssrc_o, 32'hC0DE_F00D);
		chk("retx kind", kind_cap, 4);
		cfg_ld_ok_i = 1;
		cfg_cols_i = 8'h03;
		rx_pkt({2'b01, 30'h0}, 32'h0009_0000);
		chk("configured cols", rx_blk_cols_o, 8'h03);
		chk("configured kind", kind_cap, 1);
		$display("test parse done");
		tally_and_finish();
	end
endmodule // rtp_fec_header_codec_test
